/* File: src/usb_device_control_core.sv */
// Summary of operation
// - After reset: disabled, core clock stopped, pad suspended, all state reset except the remaining byte store.
// - Enable bit one enables; zero disables at any time.
// - Soft reset returns every register to reset value, leaving disabled.
// - Mode and speed may be written anytime; applied only once enabled.
// - Detach zero attaches device; one detaches it.
// - Without an address, answer tokens to default address zero.
// - Accept own address only with accept enable; bus reset clears it.
// - Fetch endpoint descriptors from descriptor base as bus master.
// - Underflow during IN data stage sets RAM access error flag.
// - Disabling an endpoint clears its enables, flags and stall bits.
// - Split a software buffer into maximum-size packets automatically.
// - Bus reset clears configs but zero, frame, address, flags, stalls, resume.
// - End of bus reset sets the end-of-reset flag.
// - Writes may be protected except flag registers; debug lifts protection.
// - Keep operating while the CPU is halted in debug.
// - Provide a 1 kHz start-of-frame pulse in both modes.
// - Register writes affecting the core are synchronised before acting.
// - Recover the received bit clock with a digital phase tracker.
// - Keep working in sleep; events can wake the system.
// - Start-of-frame stores frame number, sets flag, flags token errors.
// - Tokens for another address are dropped and the engine idles.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ctl_map.svh"

module usb_device_control_core
#(
   parameter int unsigned SOF_PERIOD = `SOF_PERIOD_CYC
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire usb_ctl_pkg::reg_req_s reg_req_i,
   output logic [31:0] reg_rdata_o,
   input wire logic prot_lock_i,
   input wire logic debug_halt_i,
   input wire logic dbg_access_i,
   input wire usb_ctl_pkg::token_s token_i,
   input wire logic bus_reset_i,
   input wire logic in_underflow_i,
   input wire logic rx_dp_i,
   output logic rx_bit_o,
   output logic rx_bit_valid_o,
   output usb_ctl_pkg::ahb_req_s ahb_o,
   input wire logic [31:0] hrdata_i,
   input wire logic hready_i,
   output usb_ctl_pkg::packet_s packet_o,
   output logic token_drop_o,
   output logic core_clk_en_o,
   output logic pad_suspend_o,
   output logic attach_o,
   output logic host_mode_o,
   output logic [1:0] speed_o,
   output logic sof_pulse_o,
   output logic wake_o
);
   import usb_ctl_pkg::*;

   // ****************************************
   // Reset and register write decode
   // ****************************************
   logic soft_reset_bit_q;
   logic rst;
   logic wr_ok;
   logic is_flag_reg;
   assign rst = !rstn_i || soft_reset_bit_q;
   assign is_flag_reg = (reg_req_i.addr == `OFS_DEV_FLAGS)
      || (reg_req_i.addr[7:5] == 3'h3);
   // Debug halt and debugger accesses bypass the lock so a halted CPU can be patched.
   assign wr_ok = reg_req_i.we && (!prot_lock_i || debug_halt_i || dbg_access_i
      || is_flag_reg);

   logic enable_q;
   logic mode_q;
   logic detach_q;
   logic up_resume_q;
   logic [1:0] speed_cfg_q;
   logic [6:0] dev_addr_q;
   logic addr_en_q;
   logic [31:0] desc_base_q;
   logic [15:0] pad_trim_q;
   logic [2:0] dev_flags_q;
   logic [10:0] frame_q;
   logic frame_err_q;
   logic [2:0] ep_cfg_q [8];
   logic [7:0] ep_en_q [8];
   logic [7:0] ep_flag_q [8];
   logic [1:0] ep_stall_q [8];
   logic [7:0] summary;
   logic [7:0] ep_done;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         soft_reset_bit_q <= 1'b0;
      end
      else
      begin
         soft_reset_bit_q <= wr_ok && reg_req_i.addr == `OFS_CONTROL_ONE
            && reg_req_i.wdata[`BIT_SOFT_RESET];
      end
   end

   // ****************************************
   // Link input synchronisers
   // ****************************************
   token_s tok_s1_q;
   token_s tok_s2_q;
   logic [2:0] lvl_s1_q;
   logic [2:0] lvl_s2_q;
   logic tok_seen_q;
   logic brst_seen_q;
   logic undf_seen_q;
   logic tok_ev;
   logic brst_rise;
   logic brst_fall;
   logic undf_ev;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         tok_s1_q <= '0;
         tok_s2_q <= '0;
         lvl_s1_q <= 3'h0;
         lvl_s2_q <= 3'h0;
         tok_seen_q <= 1'b0;
         brst_seen_q <= 1'b0;
         undf_seen_q <= 1'b0;
      end
      else
      begin
         tok_s1_q <= token_i;
         tok_s2_q <= tok_s1_q;
         lvl_s1_q <= {rx_dp_i, in_underflow_i, bus_reset_i};
         lvl_s2_q <= lvl_s1_q;
         tok_seen_q <= tok_s2_q.valid;
         brst_seen_q <= lvl_s2_q[0];
         undf_seen_q <= lvl_s2_q[1];
      end
   end

   logic core_on_q;
   assign tok_ev = tok_s2_q.valid && !tok_seen_q && core_on_q && !host_mode_o;
   assign brst_rise = lvl_s2_q[0] && !brst_seen_q && core_on_q;
   assign brst_fall = !lvl_s2_q[0] && brst_seen_q && core_on_q;
   assign undf_ev = lvl_s2_q[1] && !undf_seen_q && core_on_q;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst)
      begin
         enable_q <= 1'b0;
         mode_q <= 1'b0;
         detach_q <= 1'(`RST_CONTROL_TWO);
         up_resume_q <= 1'b0;
         speed_cfg_q <= 2'h0;
         desc_base_q <= 32'h0;
         pad_trim_q <= 16'h0;
      end
      else
      begin
         if (wr_ok && reg_req_i.addr == `OFS_CONTROL_ONE)
         begin
            enable_q <= reg_req_i.wdata[`BIT_ENABLE] && !reg_req_i.wdata[`BIT_SOFT_RESET];
            mode_q <= reg_req_i.wdata[`BIT_MODE];
         end
         else if (wr_ok && reg_req_i.addr == `OFS_CONTROL_TWO)
         begin
            detach_q <= reg_req_i.wdata[`BIT_DETACH];
            speed_cfg_q <= reg_req_i.wdata[3:2];
         end
         else if (wr_ok && reg_req_i.addr == `OFS_DESC_BASE)
         begin
            desc_base_q <= reg_req_i.wdata;
         end
         else if (wr_ok && reg_req_i.addr == `OFS_PAD_TRIM)
         begin
            pad_trim_q <= reg_req_i.wdata[15:0];
         end
         if (brst_rise)
         begin
            up_resume_q <= 1'b0;
         end
         else if (wr_ok && reg_req_i.addr == `OFS_CONTROL_TWO)
         begin
            up_resume_q <= reg_req_i.wdata[`BIT_UP_RESUME];
         end
      end
   end

   // ****************************************
   // Core enable crossing and applied mode
   // ****************************************
   // The enable passes two stages so the core never sees a half-written setting.
   logic en_s1_q;
   always_ff @(posedge clk_i)
   begin
      if (rst)
      begin
         en_s1_q <= 1'b0;
         core_on_q <= 1'b0;
         core_clk_en_o <= 1'b0;
         pad_suspend_o <= 1'b1;
         attach_o <= 1'b0;
         host_mode_o <= 1'b0;
         speed_o <= 2'h0;
      end
      else
      begin
         en_s1_q <= enable_q;
         core_on_q <= en_s1_q;
         core_clk_en_o <= en_s1_q;
         pad_suspend_o <= !en_s1_q;
         attach_o <= en_s1_q && !mode_q && !detach_q;
         if (en_s1_q && !core_on_q)
         begin
            host_mode_o <= mode_q;
            speed_o <= speed_cfg_q;
         end
      end
   end

   // ****************************************
   // Address, frame and device flags
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst || brst_rise)
      begin
         dev_addr_q <= 7'h0;
         addr_en_q <= 1'b0;
         frame_q <= 11'h0;
         frame_err_q <= 1'b0;
      end
      else
      begin
         if (wr_ok && reg_req_i.addr == `OFS_DEV_ADDR)
         begin
            dev_addr_q <= reg_req_i.wdata[6:0];
            addr_en_q <= reg_req_i.wdata[`BIT_ADDR_EN];
         end
         if (tok_ev && tok_s2_q.sof)
         begin
            frame_q <= tok_s2_q.frame;
            frame_err_q <= tok_s2_q.err;
         end
      end
   end

   logic [2:0] dev_set;
   assign dev_set = {undf_ev, brst_fall, tok_ev && tok_s2_q.sof};

   always_ff @(posedge clk_i)
   begin
      if (rst)
      begin
         dev_flags_q <= 3'h0;
      end
      else
      begin
         // A flag raised in the same cycle as its clear survives.
         if (wr_ok && reg_req_i.addr == `OFS_DEV_FLAGS)
         begin
            dev_flags_q <= (dev_flags_q & ~reg_req_i.wdata[2:0]) | dev_set;
         end
         else
         begin
            dev_flags_q <= dev_flags_q | dev_set;
         end
      end
   end

   // ****************************************
   // Per-endpoint registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_ep
         logic cfg_wr;
         logic dis;
         assign cfg_wr = wr_ok && reg_req_i.addr == (`OFS_EP_CONFIG + 8'(g * 4));
         assign dis = cfg_wr && reg_req_i.wdata[2:0] == 3'h0;
         assign summary[g] = |ep_flag_q[g];
         always_ff @(posedge clk_i)
         begin
            if (rst || (brst_rise && g != 0))
            begin
               ep_cfg_q[g] <= 3'h0;
            end
            else if (cfg_wr)
            begin
               ep_cfg_q[g] <= reg_req_i.wdata[2:0];
            end
         end
         always_ff @(posedge clk_i)
         begin
            if (rst || brst_rise || dis)
            begin
               ep_en_q[g] <= 8'h0;
               ep_flag_q[g] <= 8'h0;
               ep_stall_q[g] <= 2'h0;
            end
            else
            begin
               if (wr_ok && reg_req_i.addr == (`OFS_EP_IRQ_EN + 8'(g * 4)))
               begin
                  ep_en_q[g] <= reg_req_i.wdata[7:0];
               end
               if (wr_ok && reg_req_i.addr == (`OFS_EP_FLAGS + 8'(g * 4)))
               begin
                  ep_flag_q[g] <= (ep_flag_q[g] & ~reg_req_i.wdata[7:0])
                     | {7'h0, ep_done[g]};
               end
               else
               begin
                  ep_flag_q[g] <= ep_flag_q[g] | {7'h0, ep_done[g]};
               end
               if (wr_ok && reg_req_i.addr == (`OFS_EP_STALL + 8'(g * 4)))
               begin
                  ep_stall_q[g] <= reg_req_i.wdata[1:0];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Token filter and descriptor fetch
   // ****************************************
   dma_state_e state_q;
   logic [2:0] ep_q;
   logic [31:0] buf_q;
   logic [13:0] max_q;
   logic [13:0] total_q;
   logic [13:0] rem_rd;
   logic [13:0] rem_now;
   logic [13:0] len;
   logic rem_we;
   logic [7:0] rem_ok_q;
   logic addr_hit;
   assign addr_hit = addr_en_q ? (tok_s2_q.addr == dev_addr_q)
      : (tok_s2_q.addr == 7'h0);
   // The count store has no reset, so an entry is trusted only once it has been written.
   assign rem_now = (!rem_ok_q[ep_q] || rem_rd == 14'h0) ? total_q : rem_rd;
   assign len = (rem_now > max_q) ? max_q : rem_now;
   assign rem_we = state_q == ST_EMIT;

   always_ff @(posedge clk_i)
   begin
      if (rst || brst_rise)
      begin
         state_q <= ST_IDLE;
         ep_q <= 3'h0;
         buf_q <= 32'h0;
         max_q <= 14'h0;
         total_q <= 14'h0;
         rem_ok_q <= 8'h0;
         ahb_o <= '0;
         packet_o <= '0;
         token_drop_o <= 1'b0;
         ep_done <= 8'h0;
      end
      else
      begin
         packet_o.valid <= 1'b0;
         token_drop_o <= 1'b0;
         ep_done <= 8'h0;
         case (state_q)
            ST_IDLE:
            begin
               if (tok_ev && !tok_s2_q.sof)
               begin
                  if (addr_hit && ep_cfg_q[tok_s2_q.ep] != 3'h0)
                  begin
                     ep_q <= tok_s2_q.ep;
                     ahb_o.haddr <= desc_base_q + {26'h0, tok_s2_q.ep, 3'h0};
                     ahb_o.htrans <= 2'h2;
                     state_q <= ST_ADR0;
                  end
                  else
                  begin
                     token_drop_o <= 1'b1;
                  end
               end
            end
            ST_ADR0:
            begin
               if (hready_i)
               begin
                  ahb_o.haddr <= ahb_o.haddr + 32'h4;
                  state_q <= ST_ADR1;
               end
            end
            ST_ADR1:
            begin
               if (hready_i)
               begin
                  buf_q <= hrdata_i;
                  ahb_o.htrans <= 2'h0;
                  state_q <= ST_DAT1;
               end
            end
            ST_DAT1:
            begin
               if (hready_i)
               begin
                  max_q <= {4'h0, hrdata_i[9:0]};
                  total_q <= hrdata_i[23:10];
                  state_q <= ST_EMIT;
               end
            end
            ST_EMIT:
            begin
               packet_o.valid <= 1'b1;
               packet_o.ep <= ep_q;
               packet_o.addr <= buf_q + {18'h0, total_q - rem_now};
               packet_o.len <= len;
               ep_done[ep_q] <= rem_now == len;
               rem_ok_q[ep_q] <= 1'b1;
               state_q <= ST_IDLE;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   rem_mem u_rem
   (
      .clk_i(clk_i),
      .we_i(rem_we),
      .waddr_i(ep_q),
      .wdata_i(rem_now - len),
      .raddr_i(ep_q),
      .rdata_o(rem_rd)
   );

   // ****************************************
   // Frame pulse, bit recovery and wake
   // ****************************************
   logic [15:0] sof_cnt_q;
   logic [1:0] ph_q;
   logic rx_last_q;
   always_ff @(posedge clk_i)
   begin
      if (rst)
      begin
         sof_cnt_q <= 16'h0;
         sof_pulse_o <= 1'b0;
         ph_q <= 2'h0;
         rx_last_q <= 1'b0;
         rx_bit_o <= 1'b0;
         rx_bit_valid_o <= 1'b0;
         wake_o <= 1'b0;
      end
      else
      begin
         sof_pulse_o <= 1'b0;
         if (!core_on_q || sof_cnt_q == 16'(SOF_PERIOD - 1))
         begin
            sof_cnt_q <= 16'h0;
            sof_pulse_o <= core_on_q;
         end
         else
         begin
            sof_cnt_q <= sof_cnt_q + 16'h1;
         end
         // Each line edge re-centres the phase; sampling falls mid-bit.
         rx_last_q <= lvl_s2_q[2];
         ph_q <= (lvl_s2_q[2] != rx_last_q) ? 2'h0 : ph_q + 2'h1;
         rx_bit_valid_o <= core_on_q && ph_q == 2'(`RX_BIT_CYC / 2 - 1);
         rx_bit_o <= lvl_s2_q[2];
         wake_o <= (|dev_flags_q) || (|summary);
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst)
      begin
         reg_rdata_o <= 32'h0;
      end
      else if (reg_req_i.re)
      begin
         if (reg_req_i.addr == `OFS_CONTROL_ONE)
            reg_rdata_o <= {29'h0, mode_q, 1'b0, enable_q};
         else if (reg_req_i.addr == `OFS_CONTROL_TWO)
            reg_rdata_o <= {28'h0, speed_cfg_q, up_resume_q, detach_q};
         else if (reg_req_i.addr == `OFS_DEV_ADDR)
            reg_rdata_o <= {24'h0, addr_en_q, dev_addr_q};
         else if (reg_req_i.addr == `OFS_DESC_BASE)
            reg_rdata_o <= desc_base_q;
         else if (reg_req_i.addr == `OFS_DEV_FLAGS)
            reg_rdata_o <= {29'h0, dev_flags_q};
         else if (reg_req_i.addr == `OFS_FRAME)
            reg_rdata_o <= {16'h0, frame_err_q, 4'h0, frame_q};
         else if (reg_req_i.addr == `OFS_EP_SUMMARY)
            reg_rdata_o <= {24'h0, summary};
         else if (reg_req_i.addr == `OFS_PAD_TRIM)
            reg_rdata_o <= {16'h0, pad_trim_q};
         else if (reg_req_i.addr[7:5] == 3'h1 && reg_req_i.addr[1:0] == 2'h0)
            reg_rdata_o <= {29'h0, ep_cfg_q[reg_req_i.addr[4:2]]};
         else if (reg_req_i.addr[7:5] == 3'h2 && reg_req_i.addr[1:0] == 2'h0)
            reg_rdata_o <= {24'h0, ep_en_q[reg_req_i.addr[4:2]]};
         else if (reg_req_i.addr[7:5] == 3'h3 && reg_req_i.addr[1:0] == 2'h0)
            reg_rdata_o <= {24'h0, ep_flag_q[reg_req_i.addr[4:2]]};
         else if (reg_req_i.addr[7:5] == 3'h4 && reg_req_i.addr[1:0] == 2'h0)
            reg_rdata_o <= {30'h0, ep_stall_q[reg_req_i.addr[4:2]]};
         else
            reg_rdata_o <= 32'h0;
      end
      else
      begin
         reg_rdata_o <= 32'h0;
      end
   end
endmodule

`default_nettype wire

/* File: inc/usb_ctl_map.svh */
`ifndef USB_CTL_MAP_SVH
`define USB_CTL_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_TWO 8'h04
`define OFS_DEV_ADDR 8'h08
`define OFS_DESC_BASE 8'h0C
`define OFS_DEV_FLAGS 8'h10
`define OFS_FRAME 8'h14
`define OFS_EP_SUMMARY 8'h18
`define OFS_PAD_TRIM 8'h1C
`define OFS_EP_CONFIG 8'h20
`define OFS_EP_IRQ_EN 8'h40
`define OFS_EP_FLAGS 8'h60
`define OFS_EP_STALL 8'h80

// ****************************************
// Field positions
// ****************************************
`define BIT_ENABLE 0
`define BIT_SOFT_RESET 1
`define BIT_MODE 2
`define BIT_DETACH 0
`define BIT_UP_RESUME 1
`define BIT_ADDR_EN 7
`define BIT_FLAG_SOF 0
`define BIT_FLAG_END_OF_RESET_FLAG 1
`define BIT_FLAG_RAMERR 2
`define BIT_FN_ERR 15
`define BIT_EP_DONE 0

// ****************************************
// Reset values and timing
// ****************************************
`define RST_CONTROL_TWO 4'h1
`define CLK_MHZ 50
`define SOF_PERIOD_US 1000
`define SOF_PERIOD_CYC (`SOF_PERIOD_US * `CLK_MHZ)
`define RX_BIT_CYC 4

`endif

/* File: inc/usb_ctl_pkg.sv */
package usb_ctl_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [2:0] ep;
      logic sof;
      logic err;
      logic [10:0] frame;
   } token_s;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
   } ahb_req_s;

   typedef struct packed {
      logic valid;
      logic [2:0] ep;
      logic [31:0] addr;
      logic [13:0] len;
   } packet_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADR0 = 3'b001,
      ST_ADR1 = 3'b011,
      ST_DAT1 = 3'b010,
      ST_EMIT = 3'b110
   } dma_state_e;

endpackage

/* File: src/rem_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Per-endpoint remaining byte store
// ****************************************
module rem_mem
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [2:0] waddr_i,
   input wire logic [13:0] wdata_i,
   input wire logic [2:0] raddr_i,
   output logic [13:0] rdata_o
);
   logic [13:0] mem_q [8];

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule

`default_nettype wire

/* File: tb/ahb_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Descriptor RAM behind the bus master
// ****
module ahb_ram_model
(
   input wire logic clk_i,
   input wire usb_ctl_pkg::ahb_req_s ahb_i,
   input wire logic slow_i,
   output logic [31:0] hrdata_o,
   output logic hready_o
);
   import usb_ctl_pkg::*;
   logic [31:0] mem [0:15];
   logic [3:0] idx_q = 4'h0;
   logic act_q = 1'b0;
   logic tog_q = 1'b0;
   // Slow mode stalls every other cycle, so waits are exercised.
   assign hready_o = !slow_i || tog_q;
   // Outside a data phase the bus shows a toggling pattern, never stale data.
   assign hrdata_o = act_q ? mem[idx_q] : {16{tog_q, ~tog_q}};
   always @(posedge clk_i)
   begin
      tog_q <= ~tog_q;
      if (hready_o)
      begin
         act_q <= (ahb_i.htrans == 2'h2);
         idx_q <= ahb_i.haddr[5:2];
      end
   end
endmodule
`default_nettype wire

/* File: tb/usb_ctl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker
// ****
module usb_ctl_monitor
#(
   parameter int unsigned SOF_PERIOD = 50
)
(
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic bus_reset_i,
   input wire usb_ctl_pkg::ahb_req_s ahb_o,
   input wire usb_ctl_pkg::packet_s packet_o,
   input wire logic token_drop_o,
   input wire logic core_clk_en_o,
   input wire logic pad_suspend_o,
   input wire logic sof_pulse_o
);
   import usb_ctl_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   int unsigned cnt_q;
   logic seen_q;
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || !core_clk_en_o)
      begin
         cnt_q <= 0;
         seen_q <= 1'b0;
      end
      else if (sof_pulse_o)
      begin
         cnt_q <= 0;
         seen_q <= 1'b1;
      end
      else
         cnt_q <= cnt_q + 1;
   end
   sequence s_start;
      $rose(ahb_o.htrans == 2'h2);
   endsequence
   sequence s_emit;
      ##[2:80] packet_o.valid;
   endsequence
   property p_rst;
      $rose(rstn_i) |-> pad_suspend_o && !core_clk_en_o;
   endproperty
   property p_pad;
      core_clk_en_o |-> !pad_suspend_o;
   endproperty
   property p_fetch;
      disable iff (!rstn_i || bus_reset_i) s_start |-> s_emit;
   endproperty
   property p_read;
      ahb_o.htrans != 2'h0 |-> !ahb_o.hwrite;
   endproperty
   property p_emit;
      packet_o.valid |=> !packet_o.valid;
   endproperty
   property p_len;
      packet_o.valid |-> packet_o.len != 14'h0;
   endproperty
   property p_drop;
      token_drop_o |=> !token_drop_o;
   endproperty
   property p_drop_idle;
      token_drop_o |-> ahb_o.htrans == 2'h0;
   endproperty
   property p_sof_gap;
      sof_pulse_o && seen_q |-> cnt_q == SOF_PERIOD - 1;
   endproperty
   property p_sof_late;
      seen_q |-> cnt_q < SOF_PERIOD;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_pad: assert property (p_pad) else $error("pad awake mismatch");
   a_fetch: assert property (p_fetch) else $error("no packet");
   a_read: assert property (p_read) else $error("bus write");
   a_emit: assert property (p_emit) else $error("packet pulse long");
   a_len: assert property (p_len) else $error("empty packet");
   a_drop: assert property (p_drop) else $error("drop pulse long");
   a_drop_idle: assert property (p_drop_idle) else $error("drop busy");
   a_sof_gap: assert property (p_sof_gap) else $error("frame early");
   a_sof_late: assert property (p_sof_late) else $error("frame late");
endmodule
bind usb_device_control_core usb_ctl_monitor #(.SOF_PERIOD(SOF_PERIOD)) mon (
   .clk_i(clk_i), .rstn_i(rstn_i), .bus_reset_i(bus_reset_i), .ahb_o(ahb_o),
   .packet_o(packet_o), .token_drop_o(token_drop_o), .core_clk_en_o(core_clk_en_o),
   .pad_suspend_o(pad_suspend_o), .sof_pulse_o(sof_pulse_o));
`default_nettype wire

/* File: tb/usb_device_control_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Testbench
// ****
module usb_device_control_core_tb_top;
   import usb_ctl_pkg::*;
   logic clk_i = 0, rstn_i = 0, lock = 0, halt = 0, brst = 0, uflow = 0, rx = 0, slow = 0;
   logic [31:0] rdata, hrdata, d;
   logic hready, drop, clk_en, susp, attach, host, sof, wake, rxb, rxv, p, dr;
   logic [1:0] speed;
   reg_req_s req = '0;
   token_s tok = '0;
   ahb_req_s ahb;
   packet_s pkt, pk;
   integer fails = 0, comparisons = 0, seed = 95115, i, n, rem;
   int q[$];
   logic [2:0] rxh;
   initial forever #10 clk_i = ~clk_i;
   usb_device_control_core #(.SOF_PERIOD(50)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .reg_req_i(req), .reg_rdata_o(rdata), .prot_lock_i(lock), .debug_halt_i(halt),
      .dbg_access_i(1'b0), .token_i(tok), .bus_reset_i(brst), .in_underflow_i(uflow),
      .rx_dp_i(rx), .rx_bit_o(rxb), .rx_bit_valid_o(rxv), .ahb_o(ahb), .hrdata_i(hrdata),
      .hready_i(hready), .packet_o(pkt), .token_drop_o(drop), .core_clk_en_o(clk_en),
      .pad_suspend_o(susp), .attach_o(attach), .host_mode_o(host), .speed_o(speed),
      .sof_pulse_o(sof), .wake_o(wake));
   ahb_ram_model ram (.clk_i(clk_i), .ahb_i(ahb), .slow_i(slow), .hrdata_o(hrdata),
      .hready_o(hready));
   always @(posedge clk_i) rx <= $random(seed);
   always @(posedge clk_i) rxh <= {rxh[1:0], rx};
   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      req.addr <= a;
      req.wdata <= v;
      req.we <= 1'b1;
      @(posedge clk_i);
      req.we <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      req.addr <= a;
      req.re <= 1'b1;
      @(posedge clk_i);
      req.re <= 1'b0;
      #1 v = rdata;
   endtask
   task send(input logic [6:0] a, input logic [2:0] e, input logic s, input logic [10:0] f);
      p = 0;
      dr = 0;
      @(posedge clk_i);
      tok <= {1'b1, a, e, s, s & f[0], f};
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_i);
         #1;
         if (i == 4) tok.valid <= 1'b0;
         if (pkt.valid === 1'b1) {p, pk} = {1'b1, pkt};
         if (drop === 1'b1) dr = 1;
      end
   endtask
   task report_and_stop;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      report_and_stop;
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      #1 chk("susp", susp, 1);
      rd(8'h04, d);
      chk("ctl2", d, 1);
      wr(8'h04, 32'hD);
      repeat (6) @(posedge clk_i);
      chk("speed off", speed, 0);
      wr(8'h1C, 32'h1234);
      wr(8'h00, 32'h1);
      repeat (6) @(posedge clk_i);
      chk("clk on", {clk_en, susp, speed, host}, 5'h16);
      wr(8'h04, 32'hC);
      repeat (6) @(posedge clk_i);
      chk("attach", attach, 1);
      ram.mem[0] = 32'h3000;
      ram.mem[1] = (8 << 10) | 8;
      ram.mem[2] = 32'h2000;
      ram.mem[3] = (20 << 10) | 8;
      wr(8'h0C, 32'h100);
      wr(8'h24, 32'h1);
      for (rem = 20; rem > 0; rem -= 8) q.push_back(rem > 8 ? 8 : rem);
      for (n = 0; q.size() > 0; n += 8)
      begin
         slow = n[3];
         send(0, 1, 0, 0);
         chk("pkt", {p, pk.ep, pk.addr}, {1'b1, 3'h1, 32'h2000 + n});
         chk("len", pk.len, q.pop_front());
      end
      rd(8'h64, d);
      chk("done", d[0], 1);
      wr(8'h84, 32'h3);
      rd(8'h84, d);
      chk("stall on", d, 3);
      wr(8'h24, 32'h0);
      rd(8'h64, d);
      chk("ep flags", d, 0);
      rd(8'h84, d);
      chk("stall", d, 0);
      send(0, 1, 0, 0);
      chk("ep off", {p, dr}, 2'b01);
      wr(8'h20, 32'h1);
      send(0, 0, 0, 0);
      chk("addr0", {p, dr, pk.len}, {2'b10, 14'd8});
      send(5, 0, 0, 0);
      chk("other", {p, dr}, 2'b01);
      wr(8'h08, 32'h85);
      send(5, 0, 0, 0);
      chk("own", {p, dr}, 2'b10);
      send(0, 0, 0, 0);
      chk("old", {p, dr}, 2'b01);
      n = $random(seed) & 32'h7FF;
      send(0, 0, 1, n);
      rd(8'h14, d);
      chk("frame", d[15:0], {n[0], 4'h0, n[10:0]});
      uflow <= 1'b1;
      repeat (4) @(posedge clk_i);
      uflow <= 1'b0;
      rd(8'h10, d);
      chk("sof ram", {d[2], d[0]}, 2'b11);
      lock <= 1'b1;
      wr(8'h0C, 32'h200);
      rd(8'h0C, d);
      chk("locked", d, 32'h100);
      wr(8'h10, 32'h7);
      rd(8'h10, d);
      chk("flag w1c", d, 0);
      halt <= 1'b1;
      wr(8'h0C, 32'h200);
      rd(8'h0C, d);
      chk("halted", d, 32'h200);
      {lock, halt} <= 2'b00;
      wr(8'h24, 32'h1);
      brst <= 1'b1;
      repeat (8) @(posedge clk_i);
      brst <= 1'b0;
      repeat (6) @(posedge clk_i);
      rd(8'h08, d);
      chk("device_bus_address", d, 0);
      rd(8'h24, d);
      chk("ep1 cfg", d, 0);
      rd(8'h20, d);
      chk("ep0 cfg", d, 1);
      rd(8'h14, d);
      chk("frame_number", d, 0);
      rd(8'h10, d);
      chk("end_of_reset_flag", d[1], 1);
      chk("wake", wake, 1);
      rd(8'hF0, d);
      chk("unmapped", d, 0);
      for (i = 0; i < 200 && sof !== 1'b1; i++) @(posedge clk_i) #1;
      for (n = 1; n < 200; n++)
      begin
         @(posedge clk_i) #1;
         if (sof === 1'b1) break;
      end
      chk("sof gap", n, 50);
      chk("rx bit", rxb, rxh[2]);
      wr(8'h00, 32'h2);
      repeat (6) @(posedge clk_i);
      rd(8'h00, d);
      chk("ctl1", d, 0);
      rd(8'h04, d);
      chk("ctl2 rst", {d, susp}, {32'h1, 1'b1});
      report_and_stop;
   end
endmodule
`default_nettype wire
